// ==== bench/dram_lane_model.sv ====
// Behavioural DRAM with check bits on the far side of the memory pins.
// Assumes registered strobes from the controller and one shared clock.
`timescale 1ns/1ps
module dram_lane_model (
  input  logic        clk_in,
  input  logic [7:0]  row_n_in,
  input  logic [7:0]  col_n_in,
  input  logic        we_n_in,
  input  logic [11:0] addr_in,
  input  logic [63:0] dq_in,
  input  logic        dq_oe_in,
  input  logic [7:0]  chk_in,
  input  logic        corrupt_in,
  output logic [63:0] dq_out,
  output logic [7:0]  chk_out
);
  logic [63:0] data_q [16];
  logic [7:0]  chk_q  [16];
  logic [63:0] junk = 64'h5A3C_96E1_0F87_C3A5;
  logic        col_on;

  initial begin
    for (int i = 0; i < 16; i++) begin
      data_q[i] = '0;
      chk_q[i] = '0;
    end
  end

  // Read answer during the column cycle, changing junk otherwise
  assign col_on = col_n_in != 8'hFF && row_n_in != 8'hFF;
  assign dq_out = (col_on && we_n_in) ? data_q[addr_in[3:0]] : junk;
  assign chk_out = (col_on && we_n_in) ?
    chk_q[addr_in[3:0]] ^ {7'h00, corrupt_in} : junk[7:0];

  // Store each lane whose column strobe is low on a write
  always @(posedge clk_in) begin
    junk <= ~junk;
    if (col_on && !we_n_in && dq_oe_in) begin
      for (int k = 0; k < 8; k++) begin
        if (!col_n_in[k]) begin
          data_q[addr_in[3:0]][8*k +: 8] <= dq_in[8*k +: 8];
          chk_q[addr_in[3:0]][k] <= chk_in[k];
        end
      end
    end
  end
endmodule

// ==== bench/mem_lane_checker.sv ====
// Concurrent checks on the pins of memory_lane_and_l2_control.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module mem_lane_checker (
  input wire        clk_in,
  input wire        nrst_in,
  input wire        cmd_valid_in,
  input wire        cmd_ready_out,
  input wire [2:0]  cmd_bank_in,
  input wire [11:0] cmd_row_in,
  input wire        check_en_in,
  input wire [11:0] mem_mux_addr_out,
  input wire [7:0]  row_strobe_n_out,
  input wire [7:0]  col_strobe_n_out,
  input wire        dram_write_en0_n_out,
  input wire        dram_write_en1_n_out,
  input wire [63:0] mem_data_bus_out,
  input wire [7:0]  mem_check_bus_out,
  input wire        mem_check_bus_oe_out,
  input wire        cache_start_in,
  input wire        cache_advance_in,
  input wire        cache_addr_strobe_n_out,
  input wire        cache_burst_advance_n_out,
  input wire        sram_latch_en_out,
  input wire        tag_flush_in,
  input wire        tag_fill_in,
  input wire        tag_inval_in,
  input wire        tag_flush_n_out,
  input wire        tag_valid_out,
  input wire        tag_write_en_n_out,
  input wire        tag_match_in,
  input wire        cache_hit_out
);
  logic [2:0]  bank_ff;
  logic [11:0] row_ff;
  logic [7:0]  lane_par;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // Remember bank and row of the command just taken
  always @(posedge clk_in) begin
    if (cmd_valid_in && cmd_ready_out) begin
      bank_ff <= cmd_bank_in;
      row_ff <= cmd_row_in;
    end
  end

  // Even parity of each driven data lane
  for (genvar k = 0; k < 8; k++) begin : g_par
    assign lane_par[k] = ^mem_data_bus_out[8*k +: 8];
  end

  // ==========================================================
  // DRAM pins
  a_we_pair: assert property
    (dram_write_en0_n_out == dram_write_en1_n_out)
    else $error("write enables differ");
  a_row_open: assert property
    (cmd_valid_in && cmd_ready_out |=> ##[1:2]
    (row_strobe_n_out == ~(8'h01 << bank_ff) && mem_mux_addr_out == row_ff))
    else $error("row strobe or row address wrong");
  a_row_single: assert property ($onehot0(~row_strobe_n_out))
    else $error("more than one row strobe");
  a_col_in_row: assert property
    (col_strobe_n_out != 8'hFF |-> row_strobe_n_out != 8'hFF)
    else $error("column strobe without row");
  a_check_gen: assert property
    (mem_check_bus_oe_out && check_en_in |-> mem_check_bus_out == lane_par)
    else $error("check bits not even parity");

  // ==========================================================
  // Level-two cache pins
  a_latch_high: assert property (sram_latch_en_out)
    else $error("address latch enable low");
  a_ads_pulse: assert property
    ($past(nrst_in) |-> !cache_addr_strobe_n_out == $past(cache_start_in))
    else $error("address strobe mismatch");
  a_cnt_step: assert property
    ($past(nrst_in) |-> !cache_burst_advance_n_out
    == $past(cache_advance_in && !cache_start_in))
    else $error("count enable mismatch");
  a_flush_follow: assert property
    ($past(nrst_in) |-> tag_flush_n_out == !$past(tag_flush_in))
    else $error("tag flush mismatch");
  a_tag_write: assert property
    (tag_fill_in || tag_inval_in
    |=> !tag_write_en_n_out && tag_valid_out == !$past(tag_inval_in))
    else $error("tag write wrong");
  a_tag_quiet: assert property
    (!tag_write_en_n_out |-> $past(tag_fill_in || tag_inval_in))
    else $error("tag write without request");
  a_hit_follow: assert property
    ($past(nrst_in) |-> cache_hit_out == $past(tag_match_in))
    else $error("hit does not follow match");
endmodule

bind memory_lane_and_l2_control mem_lane_checker i_chk (.clk_in, .nrst_in,
  .cmd_valid_in, .cmd_ready_out, .cmd_bank_in, .cmd_row_in, .check_en_in,
  .mem_mux_addr_out, .row_strobe_n_out, .col_strobe_n_out,
  .dram_write_en0_n_out, .dram_write_en1_n_out, .mem_data_bus_out,
  .mem_check_bus_out, .mem_check_bus_oe_out, .cache_start_in,
  .cache_advance_in, .cache_addr_strobe_n_out, .cache_burst_advance_n_out,
  .sram_latch_en_out, .tag_flush_in, .tag_fill_in, .tag_inval_in,
  .tag_flush_n_out, .tag_valid_out, .tag_write_en_n_out, .tag_match_in,
  .cache_hit_out);

// ==== bench/tb_memory_lane_and_l2_control.sv ====
// Self-checking bench for memory_lane_and_l2_control.
// Assumes dram_lane_model on the memory pins and the bound checker.
`timescale 1ns/1ps
module tb_memory_lane_and_l2_control;
  logic        clk_in, nrst_in, ce_in, big_endian_steering_in, check_en_in;
  logic        cmd_valid_in, cmd_ready_out, cmd_write_in, corrupt;
  logic        burst_indicator_n_in, wr_data_valid_in, wr_data_ready_out;
  logic        rd_valid_out, rd_ready_in, check_error_out, check_error_clr_in;
  logic        dram_write_en0_n_out, dram_write_en1_n_out;
  logic        mem_data_bus_oe_out, mem_check_bus_oe_out, cache_start_in;
  logic        cache_advance_in, cache_addr_strobe_n_out, sram_latch_en_out;
  logic        cache_burst_advance_n_out, tag_flush_in, tag_fill_in;
  logic        tag_inval_in, tag_flush_n_out, tag_valid_out, cache_hit_out;
  logic        tag_write_en_n_out, tag_match_in;
  logic [2:0]  cmd_bank_in;
  logic [11:0] cmd_row_in, cmd_col_in, mem_mux_addr_out;
  logic [7:0]  cmd_lanes_in, row_strobe_n_out, col_strobe_n_out;
  logic [7:0]  mem_check_bus_in, mem_check_bus_out;
  logic [0:63] wr_data_in, rd_data_out;
  logic [63:0] mem_data_bus_in, mem_data_bus_out;
  logic [63:0] pat [4];
  int          fail_count = 0, checks_done = 0, cycles = 0;

  memory_lane_and_l2_control i_dut (.clk_in, .nrst_in, .ce_in,
    .big_endian_steering_in, .check_en_in, .cmd_valid_in, .cmd_ready_out,
    .cmd_write_in, .burst_indicator_n_in, .cmd_bank_in, .cmd_row_in,
    .cmd_col_in, .cmd_lanes_in, .wr_data_in, .wr_data_valid_in,
    .wr_data_ready_out, .rd_data_out, .rd_valid_out, .rd_ready_in,
    .check_error_out, .check_error_clr_in, .mem_mux_addr_out,
    .row_strobe_n_out, .col_strobe_n_out, .dram_write_en0_n_out,
    .dram_write_en1_n_out, .mem_data_bus_in, .mem_data_bus_out,
    .mem_data_bus_oe_out, .mem_check_bus_in, .mem_check_bus_out,
    .mem_check_bus_oe_out, .cache_start_in, .cache_advance_in,
    .cache_addr_strobe_n_out, .cache_burst_advance_n_out,
    .sram_latch_en_out, .tag_flush_in, .tag_fill_in, .tag_inval_in,
    .tag_flush_n_out, .tag_valid_out, .tag_write_en_n_out, .tag_match_in,
    .cache_hit_out);

  dram_lane_model i_mem (.clk_in, .row_n_in(row_strobe_n_out),
    .col_n_in(col_strobe_n_out), .we_n_in(dram_write_en0_n_out),
    .addr_in(mem_mux_addr_out), .dq_in(mem_data_bus_out),
    .dq_oe_in(mem_data_bus_oe_out), .chk_in(mem_check_bus_out),
    .corrupt_in(corrupt), .dq_out(mem_data_bus_in),
    .chk_out(mem_check_bus_in));

  // ==========================================================
  // Clock, hang guard and shared helpers
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Cut a hang short
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [63:0] swap(input logic [63:0] v);
    for (int k = 0; k < 8; k++)
      swap[8*k +: 8] = v[56-8*k +: 8];
  endfunction

  function automatic logic [7:0] par(input logic [63:0] v);
    for (int k = 0; k < 8; k++)
      par[k] = ^v[8*k +: 8];
  endfunction

  task automatic issue(input logic wr, bst, input logic [7:0] ln,
                       input logic [2:0] bk);
    int n = 0;
    @(negedge clk_in);
    cmd_write_in = wr;
    burst_indicator_n_in = bst;
    cmd_lanes_in = ln;
    cmd_bank_in = bk;
    cmd_row_in = {9'h14B, bk};
    cmd_valid_in = 1'b1;
    while (!cmd_ready_out && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
  endtask

  task automatic put(input int beats);
    int n = 0;
    for (int b = 0; b < beats; b++) begin
      wr_data_in = pat[b];
      wr_data_valid_in = 1'b1;
      while (!wr_data_ready_out && n < 100) begin
        @(negedge clk_in);
        n++;
      end
      @(negedge clk_in);
    end
    wr_data_valid_in = 1'b0;
  endtask

  // Stall the reader so the buffer fills on bursts, then drain it
  task automatic get(input int beats, input logic sw, input string what);
    int n = 0;
    int b = 0;
    repeat (10) @(negedge clk_in);
    rd_ready_in = 1'b1;
    while (b < beats && n < 200) begin
      if (rd_valid_out === 1'b1) begin
        check(what, rd_data_out, sw ? swap(pat[b]) : pat[b]);
        b++;
      end
      @(negedge clk_in);
      n++;
    end
    rd_ready_in = 1'b0;
    check("read beats", b, beats);
  endtask

  task automatic wait_idle();
    int n = 0;
    while (!cmd_ready_out && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("reset pins", {row_strobe_n_out, col_strobe_n_out,
      dram_write_en0_n_out, dram_write_en1_n_out, mem_data_bus_oe_out,
      mem_check_bus_oe_out, sram_latch_en_out, tag_valid_out,
      check_error_out}, {16'hFFFF, 7'h64});
    nrst_in = 1'b1;
  endtask

  task automatic t_be_burst();
    issue(1'b1, 1'b0, 8'hFF, 3'h2);
    put(4);
    wait_idle();
    for (int b = 0; b < 4; b++) begin
      check("word", i_mem.data_q[4+b], swap(pat[b]));
      check("bits", i_mem.chk_q[4+b], par(swap(pat[b])));
    end
    issue(1'b0, 1'b0, 8'hFF, 3'h5);
    get(4, 1'b0, "be read");
    check("no error", check_error_out, 1'b0);
  endtask

  task automatic t_le_read();
    big_endian_steering_in = 1'b0;
    issue(1'b0, 1'b0, 8'hFF, 3'h7);
    get(4, 1'b1, "le read");
  endtask

  task automatic t_lane_write();
    logic [63:0] old;
    old = i_mem.data_q[4];
    pat[0] = 64'h0F1E2D3C4B5A6978;
    issue(1'b1, 1'b1, 8'h01, 3'h0);
    put(1);
    wait_idle();
    check("lane", i_mem.data_q[4], {old[63:8], pat[0][7:0]});
  endtask

  task automatic t_check_error();
    pat[0] = i_mem.data_q[4];
    corrupt = 1'b1;
    // With checking off a bad check bit must go unnoticed
    check_en_in = 1'b0;
    issue(1'b0, 1'b1, 8'hFF, 3'h1);
    get(1, 1'b0, "unchecked read");
    wait_idle();
    check("error off", check_error_out, 1'b0);
    check_en_in = 1'b1;
    issue(1'b0, 1'b1, 8'hFF, 3'h1);
    get(1, 1'b0, "bad read");
    wait_idle();
    corrupt = 1'b0;
    check("error set", check_error_out, 1'b1);
    check_error_clr_in = 1'b1;
    @(negedge clk_in);
    check_error_clr_in = 1'b0;
    @(negedge clk_in);
    check("error clear", check_error_out, 1'b0);
  endtask

  task automatic t_tags();
    tag_fill_in = 1'b1;
    tag_match_in = 1'b1;
    cache_start_in = 1'b1;
    @(negedge clk_in);
    {tag_fill_in, tag_match_in, cache_start_in} = 3'h0;
    {cache_advance_in, tag_flush_in, tag_inval_in} = 3'h7;
    check("fill", {tag_valid_out, tag_write_en_n_out, cache_hit_out,
      cache_addr_strobe_n_out}, 4'hA);
    @(negedge clk_in);
    {cache_advance_in, tag_flush_in, tag_inval_in} = 3'h0;
    check("flush", {tag_flush_n_out, cache_burst_advance_n_out, tag_valid_out,
      tag_write_en_n_out}, 4'h0);
    @(negedge clk_in);
  endtask

  // Main sequence
  initial begin
    {nrst_in, cmd_valid_in, cmd_write_in, wr_data_valid_in, rd_ready_in,
     check_error_clr_in, cache_start_in, cache_advance_in, tag_flush_in,
     tag_fill_in, tag_inval_in, tag_match_in, corrupt} = '0;
    {ce_in, check_en_in, burst_indicator_n_in, big_endian_steering_in} = 4'hF;
    {cmd_bank_in, cmd_lanes_in, wr_data_in, cmd_row_in} = '0;
    cmd_col_in = 12'h004;
    pat = '{64'h0123456789ABCDEF, 64'hFEDCBA9876543210,
            64'h00FF00FF55AA55AA, 64'h8040201008040201};
    repeat (20) @(negedge clk_in);
    t_reset();
    t_be_burst();
    t_le_read();
    t_lane_write();
    t_check_error();
    t_tags();
    // Second reset in mid-run must bring the strobe, enable, tag valid and error pins back to idle
    nrst_in = 1'b0;
    @(negedge clk_in);
    t_reset();
    test_done();
  end
endmodule

// ==== logic/lane_buffer.v ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock, active-low asynchronous reset, clock enable.
`timescale 1ns/1ps
`include "mem_lane_defines.vh"

module lane_buffer #(
  parameter WIDTH = `MLC_DATA_W
) (
  input  wire             clk_in,
  input  wire             nrst_in,
  input  wire             ce_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0]               slot0_ff;
  reg [WIDTH-1:0]               slot1_ff;
  reg                           wr_ptr_ff;
  reg                           rd_ptr_ff;
  reg [`MLC_BUF_CNT_W-1:0]      count_ff;
  wire                          push;
  wire                          pop;

  // ==========================================================
  // Handshake terms
  assign in_ready_out  = ce_in && (count_ff != `MLC_BUF_DEPTH);
  assign out_valid_out = ce_in && (count_ff != {`MLC_BUF_CNT_W{1'b0}});
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = rd_ptr_ff ? slot1_ff : slot0_ff; // Storage is ff

  // Storage and pointers
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slot0_ff  <= {WIDTH{1'b0}};
      slot1_ff  <= {WIDTH{1'b0}};
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= {`MLC_BUF_CNT_W{1'b0}};
    end else if (ce_in) begin
      if (push) begin
        if (wr_ptr_ff) begin
          slot1_ff <= in_data_in;
        end else begin
          slot0_ff <= in_data_in;
        end
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end

endmodule

// ==== logic/mem_lane_defines.vh ====
// Constants shared by the memory lane and level-two control logic.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef MEM_LANE_DEFINES_VH
`define MEM_LANE_DEFINES_VH

// ==========================================================
// Widths of the memory and processor buses
`define MLC_ADDR_W      12
`define MLC_ADDR_MSB    11
`define MLC_DATA_W      64
`define MLC_DATA_MSB    63
`define MLC_LANES       8
`define MLC_LANE_MSB    7
`define MLC_LANE_W      8
`define MLC_BANK_W      3
`define MLC_BANK_MSB    2

// ==========================================================
// Burst sequencing
`define MLC_BEAT_W      3
`define MLC_BEAT_MSB    2
`define MLC_BURST_LAST  3'h3
`define MLC_SINGLE_LAST 3'h0
`define MLC_BEAT_ONE    3'h1
`define MLC_BEAT_ZERO   3'h0

// ==========================================================
// Reset and idle values of the pins
`define MLC_STROBES_OFF 8'hFF
`define MLC_LANES_NONE  8'h00
`define MLC_ADDR_ZERO   12'h000
`define MLC_DATA_ZERO   64'h0000000000000000
`define MLC_ONE_BANK    8'h01

// ==========================================================
// Two-entry buffer
`define MLC_BUF_PTR_W   1
`define MLC_BUF_CNT_W   2
`define MLC_BUF_DEPTH   2'h2

`endif

// ==== logic/memory_lane_and_l2_control.v ====
// Memory lane steering, DRAM strobe sequencing and level-two cache control.
// Assumes one 40 MHz clock, inputs synchronous to it, asynchronous reset.
`timescale 1ns/1ps
`include "mem_lane_defines.vh"

module memory_lane_and_l2_control (
  input  wire                      clk_in,
  input  wire                      nrst_in,
  input  wire                      ce_in,
  input  wire                      big_endian_steering_in,
  input  wire                      check_en_in,
  input  wire                      cmd_valid_in,
  output wire                      cmd_ready_out,
  input  wire                      cmd_write_in,
  input  wire                      burst_indicator_n_in,
  input  wire [`MLC_BANK_MSB:0]    cmd_bank_in,
  input  wire [`MLC_ADDR_MSB:0]    cmd_row_in,
  input  wire [`MLC_ADDR_MSB:0]    cmd_col_in,
  input  wire [`MLC_LANE_MSB:0]    cmd_lanes_in,
  input  wire [0:`MLC_DATA_MSB]    wr_data_in,
  input  wire                      wr_data_valid_in,
  output wire                      wr_data_ready_out,
  output wire [0:`MLC_DATA_MSB]    rd_data_out,
  output wire                      rd_valid_out,
  input  wire                      rd_ready_in,
  output wire                      check_error_out,
  input  wire                      check_error_clr_in,
  output wire [`MLC_ADDR_MSB:0]    mem_mux_addr_out,
  output wire [`MLC_LANE_MSB:0]    row_strobe_n_out,
  output wire [`MLC_LANE_MSB:0]    col_strobe_n_out,
  output wire                      dram_write_en0_n_out,
  output wire                      dram_write_en1_n_out,
  input  wire [`MLC_DATA_MSB:0]    mem_data_bus_in,
  output wire [`MLC_DATA_MSB:0]    mem_data_bus_out,
  output wire                      mem_data_bus_oe_out,
  input  wire [`MLC_LANE_MSB:0]    mem_check_bus_in,
  output wire [`MLC_LANE_MSB:0]    mem_check_bus_out,
  output wire                      mem_check_bus_oe_out,
  input  wire                      cache_start_in,
  input  wire                      cache_advance_in,
  output wire                      cache_addr_strobe_n_out,
  output wire                      cache_burst_advance_n_out,
  output wire                      sram_latch_en_out,
  input  wire                      tag_flush_in,
  input  wire                      tag_fill_in,
  input  wire                      tag_inval_in,
  output wire                      tag_flush_n_out,
  output wire                      tag_valid_out,
  output wire                      tag_write_en_n_out,
  input  wire                      tag_match_in,
  output wire                      cache_hit_out
);

  // ==========================================================
  // State encoding, one-hot
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ROW  = 4'h2;
  localparam [3:0] ST_COL  = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  reg  [3:0]                 state_ff;
  reg  [3:0]                 nxt_state;
  reg                        write_ff;
  reg  [`MLC_BEAT_MSB:0]     last_beat_ff;
  reg  [`MLC_BEAT_MSB:0]     beat_ff;
  reg  [`MLC_ADDR_MSB:0]     col_ff;
  reg  [`MLC_LANE_MSB:0]     lanes_ff;
  reg  [`MLC_LANE_MSB:0]     bank_sel_ff;
  reg  [`MLC_ADDR_MSB:0]     addr_ff;
  reg  [`MLC_LANE_MSB:0]     ras_n_ff;
  reg  [`MLC_LANE_MSB:0]     cas_n_ff;
  reg                        we_n_ff;
  reg  [`MLC_DATA_MSB:0]     wdata_ff;
  reg  [`MLC_LANE_MSB:0]     wcheck_ff;
  reg                        drive_ff;
  reg                        check_drive_ff;
  reg                        rd_flight_ff;
  reg                        err_ff;
  reg                        ads_n_ff;
  reg                        adv_n_ff;
  reg                        flush_n_ff;
  reg                        tag_valid_ff;
  reg                        tag_we_n_ff;
  reg                        hit_ff;
  wire                       take_cmd;
  wire                       beat_go;
  wire                       beat_last;
  wire                       buf_in_ready;
  wire [`MLC_DATA_MSB:0]     wr_mem;
  wire [`MLC_LANE_MSB:0]     wr_par;
  wire [0:`MLC_DATA_MSB]     rd_cpu;
  wire [`MLC_LANE_MSB:0]     rd_bad;
  wire [0:`MLC_DATA_MSB]     buf_out;

  // ==========================================================
  // Lane steering and per-lane parity
  // Lane g is memory bits 8g+7..8g, bit 8g+7 its top bit
  genvar g;
  generate
    for (g = 0; g < `MLC_LANES; g = g + 1) begin : lane
      // Part-select on the ascending processor bus keeps the top bit
      // of the memory lane on the lowest processor bit of the group
      assign wr_mem[g*`MLC_LANE_W +: `MLC_LANE_W] = big_endian_steering_in ?
        wr_data_in[g*`MLC_LANE_W +: `MLC_LANE_W] :
        wr_data_in[(`MLC_LANE_MSB-g)*`MLC_LANE_W +: `MLC_LANE_W];
      assign rd_cpu[g*`MLC_LANE_W +: `MLC_LANE_W] = big_endian_steering_in ?
        mem_data_bus_in[g*`MLC_LANE_W +: `MLC_LANE_W] :
        mem_data_bus_in[(`MLC_LANE_MSB-g)*`MLC_LANE_W +: `MLC_LANE_W];
      // Even parity: check bit makes the nine-bit group even
      assign wr_par[g] = ^wr_mem[g*`MLC_LANE_W +: `MLC_LANE_W];
      assign rd_bad[g] = (^mem_data_bus_in[g*`MLC_LANE_W +: `MLC_LANE_W])
                         ^ mem_check_bus_in[g];
    end
  endgenerate

  // ==========================================================
  // Request handshakes
  // Steering input is sampled on write beats and one cycle after read beats; user holds it
  assign cmd_ready_out     = ce_in && state_ff[0];
  assign take_cmd          = cmd_valid_in && cmd_ready_out;
  // A read beat needs buffer room and no beat still in flight
  assign beat_go           = ce_in && state_ff[2] &&
                             (write_ff ? wr_data_valid_in :
                              (buf_in_ready && !rd_flight_ff));
  assign wr_data_ready_out = beat_go && write_ff;
  assign beat_last         = (beat_ff == last_beat_ff);

  // Next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take_cmd) begin
          nxt_state = ST_ROW;
        end
      end
      ST_ROW: begin
        nxt_state = ST_COL;
      end
      ST_COL: begin
        if (beat_go && beat_last) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!rd_flight_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // DRAM sequencing: row, then one column beat per transfer
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff       <= ST_IDLE;
      write_ff       <= 1'b0;
      last_beat_ff   <= `MLC_SINGLE_LAST;
      beat_ff        <= `MLC_BEAT_ZERO;
      col_ff         <= `MLC_ADDR_ZERO;
      lanes_ff       <= `MLC_LANES_NONE;
      bank_sel_ff    <= `MLC_LANES_NONE;
      addr_ff        <= `MLC_ADDR_ZERO;
      ras_n_ff       <= `MLC_STROBES_OFF;
      cas_n_ff       <= `MLC_STROBES_OFF;
      we_n_ff        <= 1'b1;
      wdata_ff       <= `MLC_DATA_ZERO;
      wcheck_ff      <= `MLC_LANES_NONE;
      drive_ff       <= 1'b0;
      check_drive_ff <= 1'b0;
      rd_flight_ff   <= 1'b0;
    end else if (ce_in) begin
      state_ff     <= nxt_state;
      rd_flight_ff <= beat_go && !write_ff;
      cas_n_ff     <= `MLC_STROBES_OFF;
      if (take_cmd) begin
        write_ff     <= cmd_write_in;
        // Burst is four double-words, else a single beat
        last_beat_ff <= burst_indicator_n_in ? `MLC_SINGLE_LAST :
                        `MLC_BURST_LAST;
        lanes_ff     <= burst_indicator_n_in ? cmd_lanes_in :
                        `MLC_STROBES_OFF;
        beat_ff      <= `MLC_BEAT_ZERO;
        col_ff       <= cmd_col_in;
        bank_sel_ff  <= `MLC_ONE_BANK << cmd_bank_in;
        addr_ff      <= cmd_row_in;
      end
      if (state_ff[1]) begin
        ras_n_ff <= ~bank_sel_ff;
        we_n_ff  <= ~write_ff;
      end
      if (beat_go) begin
        // Column of this beat, bursts step in order
        addr_ff  <= col_ff + {{(`MLC_ADDR_W-`MLC_BEAT_W){1'b0}}, beat_ff};
        cas_n_ff <= ~lanes_ff;
        beat_ff  <= beat_ff + `MLC_BEAT_ONE;
        if (write_ff) begin
          wdata_ff  <= wr_mem;
          wcheck_ff <= wr_par;
        end
      end
      drive_ff       <= beat_go ? write_ff : drive_ff && !state_ff[3];
      check_drive_ff <= beat_go ? (write_ff && check_en_in) :
                        check_drive_ff && !state_ff[3];
      if (state_ff[3]) begin
        ras_n_ff <= `MLC_STROBES_OFF;
        we_n_ff  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read check and sticky error; a new error wins over a clear
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      err_ff <= 1'b0;
    end else if (ce_in) begin
      if (rd_flight_ff && check_en_in && (|rd_bad)) begin
        err_ff <= 1'b1;
      end else if (check_error_clr_in) begin
        err_ff <= 1'b0;
      end
    end
  end

  // Read data path through the two-entry buffer
  lane_buffer #(
    .WIDTH (`MLC_DATA_W)
  ) u_read_buffer (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .ce_in         (ce_in),
    .in_valid_in   (rd_flight_ff),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (rd_cpu),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (buf_out)
  );

  // ==========================================================
  // Level-two SRAM and tag RAM controls
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ads_n_ff     <= 1'b1;
      adv_n_ff     <= 1'b1;
      flush_n_ff   <= 1'b1;
      tag_valid_ff <= 1'b0;
      tag_we_n_ff  <= 1'b1;
      hit_ff       <= 1'b0;
    end else if (ce_in) begin
      ads_n_ff    <= ~cache_start_in;
      adv_n_ff    <= ~(cache_advance_in && !cache_start_in);
      flush_n_ff  <= ~tag_flush_in;
      tag_we_n_ff <= ~(tag_fill_in || tag_inval_in);
      if (tag_inval_in) begin
        tag_valid_ff <= 1'b0;
      end else if (tag_fill_in) begin
        tag_valid_ff <= 1'b1;
      end
      hit_ff <= tag_match_in;
    end
  end

  // ==========================================================
  // Output assignments
  assign mem_mux_addr_out          = addr_ff;
  assign row_strobe_n_out          = ras_n_ff;
  assign col_strobe_n_out          = cas_n_ff;
  assign dram_write_en0_n_out      = we_n_ff;
  assign dram_write_en1_n_out      = we_n_ff;
  assign mem_data_bus_out          = wdata_ff;
  assign mem_data_bus_oe_out       = drive_ff;
  assign mem_check_bus_out         = wcheck_ff;
  assign mem_check_bus_oe_out      = check_drive_ff;
  assign rd_data_out               = buf_out;
  assign check_error_out           = err_ff;
  assign cache_addr_strobe_n_out   = ads_n_ff;
  assign cache_burst_advance_n_out = adv_n_ff;
  assign sram_latch_en_out         = 1'b1;
  assign tag_flush_n_out           = flush_n_ff;
  assign tag_valid_out             = tag_valid_ff;
  assign tag_write_en_n_out        = tag_we_n_ff;
  assign cache_hit_out             = hit_ff;

endmodule
